// *** inc/oft_pkg.sv ***
// Package of constants and types for the core A offset trim register bank.
package oft_pkg;

    // ------------------------------------------------------------------
    // Register geometry
    // ------------------------------------------------------------------
    localparam int TRIM_W = 16;
    localparam int FIELD_W = 12;
    localparam int FIELD_MSB = 11;
    localparam int TRIM_NUM = 3;
    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;
    localparam int DATA_W = 32;
    localparam int BEN_W = 4;
    localparam int LANE_W = 8;

    // Printed register indices; the byte address is four times the index.
    localparam logic [IDX_W-1:0] IDX_DUAL_INB = 10'h346;
    localparam logic [IDX_W-1:0] IDX_SINGLE_INA = 10'h348;
    localparam logic [IDX_W-1:0] IDX_SINGLE_INB = 10'h34a;
    localparam logic [IDX_W-1:0] IDX_STATUS = 10'h340;

    // Slot order of the trim registers inside the bank.
    localparam int SLOT_DUAL_INB = 0;
    localparam int SLOT_SINGLE_INA = 1;
    localparam int SLOT_SINGLE_INB = 2;
    localparam logic [TRIM_NUM-1:0][IDX_W-1:0] TRIM_IDX =
        {IDX_SINGLE_INB, IDX_SINGLE_INA, IDX_DUAL_INB};

    // ------------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------------
    localparam logic [TRIM_W-1:0] TRIM_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] RDATA_RESET = 32'h00000000;
    localparam logic [FIELD_W-1:0] OFFSET_RESET = 12'h000;
    localparam int STAT_SEL_LSB = 0;
    localparam int STAT_VALID_BIT = 2;

    // Which trim is steering core A.
    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_DUAL_INB,
        SEL_SINGLE_INA,
        SEL_SINGLE_INB
    } oft_sel_t;

endpackage

// *** inc/oft_trim_if.sv ***
// Interface between the bank and one trim register.
`timescale 1ns/10ps
interface oft_trim_if;
    logic wr_en;
    logic fuse_ld;
    logic [oft_pkg::TRIM_W-1:0] wdata;
    logic [1:0] ben;
    logic [oft_pkg::TRIM_W-1:0] fuse_data;
    logic [oft_pkg::TRIM_W-1:0] q;

    modport bank (
        output wr_en,
        output fuse_ld,
        output wdata,
        output ben,
        output fuse_data,
        input q
    );

    modport trim (
        input wr_en,
        input fuse_ld,
        input wdata,
        input ben,
        input fuse_data,
        output q
    );
endinterface

// *** rtl/oft_trim_reg.sv ***
// One 16-bit offset trim register with fuse preload and byte-lane writes.
`timescale 1ns/10ps
module oft_trim_reg (
    input wire logic clk,
    input wire logic rst,
    oft_trim_if.trim tif
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------

    // Next value: a software write wins over a fuse load in the same cycle.
    logic [oft_pkg::TRIM_W-1:0] next_q;
    logic [oft_pkg::TRIM_W-1:0] lane_mask;
    assign lane_mask = {{oft_pkg::LANE_W{tif.ben[1]}}, {oft_pkg::LANE_W{tif.ben[0]}}};
    assign next_q = tif.wr_en ? ((tif.wdata & lane_mask) | (tif.q & ~lane_mask)) :
                    tif.fuse_ld ? tif.fuse_data : tif.q;

    // The whole word, reserved bits included, resets to zero.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tif.q <= oft_pkg::TRIM_RESET;
        end else begin
            tif.q <= next_q;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------

    // A fuse load with no write in the same cycle lands the fuse word.
    AST_FUSE_PRELOAD: assert property (@(posedge clk) disable iff (rst)
        !rst && tif.fuse_ld && !tif.wr_en |=> tif.q == $past(tif.fuse_data))
        else $error("Fuse value not preloaded into trim register.");

    // The first edge after reset release still sees the zero reset value.
    AST_RESET_ZERO: assert property (@(posedge clk) disable iff (rst)
        $fell(rst) |-> tif.q == oft_pkg::TRIM_RESET)
        else $error("Trim register did not reset to zero.");

endmodule

// *** rtl/oft_bank.sv ***
// Core A offset trim register bank with an Avalon-MM slave and trim selection.
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/10ps
module oft_bank (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic [oft_pkg::ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [oft_pkg::DATA_W-1:0] AVS_WRITEDATA,
    input wire logic [oft_pkg::BEN_W-1:0] AVS_BYTEENABLE,
    output logic [oft_pkg::DATA_W-1:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic FUSE_LOAD,
    input wire logic [oft_pkg::TRIM_W-1:0] FUSE_DUAL_INB,
    input wire logic [oft_pkg::TRIM_W-1:0] FUSE_SINGLE_INA,
    input wire logic [oft_pkg::TRIM_W-1:0] FUSE_SINGLE_INB,
    input wire logic CORE_DUAL_MODE,
    input wire logic CORE_SAMPLE_INB,
    input wire logic CORE_PHASE_90,
    input wire logic FG_CAL_EN,
    output logic [oft_pkg::FIELD_W-1:0] OFFSET_A,
    output logic OFFSET_A_VALID
);

    // ------------------------------------------------------------------
    // Bus handshake state
    // ------------------------------------------------------------------

    typedef enum logic {
        BUS_IDLE,
        BUS_ANSWER
    } oft_bus_t;

    oft_bus_t state;
    oft_bus_t next_state;
    logic req;
    logic answering;
    logic commit_wr;
    logic capture_rd;

    // A request is held for exactly one wait cycle, then answered.
    assign req = AVS_READ | AVS_WRITE;
    assign answering = (state == BUS_ANSWER);
    assign AVS_WAITREQUEST = req & ~answering;
    assign commit_wr = AVS_WRITE & answering;
    assign capture_rd = AVS_READ & ~answering;

    // The answer state lasts one cycle so back-to-back requests restart cleanly.
    always_comb begin
        next_state = state;
        unique case (state)
            BUS_IDLE: begin
                if (req) begin
                    next_state = BUS_ANSWER;
                end
            end
            BUS_ANSWER: begin
                next_state = BUS_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            state <= BUS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------

    logic [oft_pkg::IDX_W-1:0] word_idx;
    logic [oft_pkg::TRIM_NUM-1:0] trim_hit;
    logic status_hit;
    logic any_hit;

    // Each register takes one aligned word; the low two address bits are ignored.
    assign word_idx = AVS_ADDRESS[oft_pkg::ADDR_W-1:2];
    assign status_hit = (word_idx == oft_pkg::IDX_STATUS);
    assign any_hit = (|trim_hit) | status_hit;

    // ------------------------------------------------------------------
    // Trim registers
    // ------------------------------------------------------------------

    oft_trim_if trim_bus[oft_pkg::TRIM_NUM] ();
    logic [oft_pkg::TRIM_W-1:0] fuse_vec [oft_pkg::TRIM_NUM];
    logic [oft_pkg::TRIM_W-1:0] trim_q [oft_pkg::TRIM_NUM];

    // Fuse words in slot order.
    assign fuse_vec[oft_pkg::SLOT_DUAL_INB] = FUSE_DUAL_INB;
    assign fuse_vec[oft_pkg::SLOT_SINGLE_INA] = FUSE_SINGLE_INA;
    assign fuse_vec[oft_pkg::SLOT_SINGLE_INB] = FUSE_SINGLE_INB;

    // One register per slot; a write lands only on the decoded slot.
    generate
        for (genvar i = 0; i < oft_pkg::TRIM_NUM; i++) begin : g_trim
            assign trim_hit[i] = (word_idx == oft_pkg::TRIM_IDX[i]);
            assign trim_bus[i].wr_en = commit_wr & trim_hit[i];
            assign trim_bus[i].fuse_ld = FUSE_LOAD;
            assign trim_bus[i].wdata = AVS_WRITEDATA[oft_pkg::TRIM_W-1:0];
            assign trim_bus[i].ben = AVS_BYTEENABLE[1:0];
            assign trim_bus[i].fuse_data = fuse_vec[i];
            assign trim_q[i] = trim_bus[i].q;

            oft_trim_reg u_trim (
                .clk(MCLK),
                .rst(RST),
                .tif(trim_bus[i])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Trim selection for core A
    // ------------------------------------------------------------------

    logic cond_dual_inb;
    logic cond_single_ina;
    logic cond_single_inb;
    oft_pkg::oft_sel_t next_sel;
    oft_pkg::oft_sel_t sel;
    logic [oft_pkg::FIELD_W-1:0] next_offset;
    logic next_valid;

    // Operating conditions; dual input B takes priority over the phase case.
    assign cond_dual_inb = FG_CAL_EN & CORE_DUAL_MODE & CORE_SAMPLE_INB;
    assign cond_single_ina = FG_CAL_EN & ~CORE_DUAL_MODE & ~CORE_SAMPLE_INB;
    assign cond_single_inb = FG_CAL_EN & ~CORE_DUAL_MODE & CORE_SAMPLE_INB
                             & CORE_PHASE_90;

    // Pick the slot; nothing is applied when no condition matches.
    assign next_sel = cond_dual_inb ? oft_pkg::SEL_DUAL_INB :
                      cond_single_inb ? oft_pkg::SEL_SINGLE_INB :
                      cond_single_ina ? oft_pkg::SEL_SINGLE_INA :
                      oft_pkg::SEL_NONE;
    assign next_valid = (next_sel != oft_pkg::SEL_NONE);

    // Only bits 11:0 reach the core; the reserved nibble never does.
    always_comb begin
        next_offset = oft_pkg::OFFSET_RESET;
        unique case (next_sel)
            oft_pkg::SEL_NONE: begin
                next_offset = oft_pkg::OFFSET_RESET;
            end
            oft_pkg::SEL_DUAL_INB: begin
                next_offset = trim_q[oft_pkg::SLOT_DUAL_INB][oft_pkg::FIELD_MSB:0];
            end
            oft_pkg::SEL_SINGLE_INA: begin
                next_offset = trim_q[oft_pkg::SLOT_SINGLE_INA][oft_pkg::FIELD_MSB:0];
            end
            oft_pkg::SEL_SINGLE_INB: begin
                next_offset = trim_q[oft_pkg::SLOT_SINGLE_INB][oft_pkg::FIELD_MSB:0];
            end
        endcase
    end

    // Registered offset and valid towards the datapath.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            sel <= oft_pkg::SEL_NONE;
            OFFSET_A <= oft_pkg::OFFSET_RESET;
            OFFSET_A_VALID <= 1'b0;
        end else begin
            sel <= next_sel;
            OFFSET_A <= next_offset;
            OFFSET_A_VALID <= next_valid;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------

    logic [oft_pkg::DATA_W-1:0] trim_rd;
    logic [oft_pkg::DATA_W-1:0] status_rd;
    logic [oft_pkg::DATA_W-1:0] next_rdata;

    // Trim words sit in the low half; unmapped addresses read zero.
    assign trim_rd = trim_hit[oft_pkg::SLOT_DUAL_INB] ?
                         {16'h0000, trim_q[oft_pkg::SLOT_DUAL_INB]} :
                     trim_hit[oft_pkg::SLOT_SINGLE_INA] ?
                         {16'h0000, trim_q[oft_pkg::SLOT_SINGLE_INA]} :
                     trim_hit[oft_pkg::SLOT_SINGLE_INB] ?
                         {16'h0000, trim_q[oft_pkg::SLOT_SINGLE_INB]} :
                         oft_pkg::RDATA_RESET;
    assign status_rd = {29'h00000000, OFFSET_A_VALID, sel};
    assign next_rdata = status_hit ? status_rd : trim_rd;

    // Read data are captured in the wait cycle and stand through the answer.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            AVS_READDATA <= oft_pkg::RDATA_RESET;
        end else if (capture_rd) begin
            AVS_READDATA <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------

    // A fresh request waits one cycle, then is answered.
    sequence s_req_start;
        !RST && !answering && req;
    endsequence

    sequence s_one_wait;
        AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
    endsequence

    AST_ONE_WAIT: assert property (@(posedge MCLK) disable iff (RST)
        s_req_start |-> s_one_wait)
        else $error("Request not answered after one wait cycle.");

    // Dual mode on input B steers the dual trim onto core A.
    AST_DUAL_INB: assert property (@(posedge MCLK) disable iff (RST)
        !RST && cond_dual_inb |=> OFFSET_A_VALID &&
            OFFSET_A == $past(trim_q[oft_pkg::SLOT_DUAL_INB][oft_pkg::FIELD_MSB:0]))
        else $error("Dual input B trim not applied.");

    // Single mode on input A steers its trim onto core A.
    AST_SINGLE_INA: assert property (@(posedge MCLK) disable iff (RST)
        !RST && cond_single_ina |=> OFFSET_A_VALID &&
            OFFSET_A == $past(trim_q[oft_pkg::SLOT_SINGLE_INA][oft_pkg::FIELD_MSB:0]))
        else $error("Single input A trim not applied.");

    // Input B on the 90 degree phase steers its trim onto core A.
    AST_SINGLE_INB: assert property (@(posedge MCLK) disable iff (RST)
        !RST && cond_single_inb |=> OFFSET_A_VALID &&
            OFFSET_A == $past(trim_q[oft_pkg::SLOT_SINGLE_INB][oft_pkg::FIELD_MSB:0]))
        else $error("Phase 90 input B trim not applied.");

    // With calibration off nothing reaches core A.
    AST_CAL_OFF: assert property (@(posedge MCLK) disable iff (RST)
        !FG_CAL_EN |=> !OFFSET_A_VALID && OFFSET_A == oft_pkg::OFFSET_RESET)
        else $error("Offset applied with calibration disabled.");

    // A change confined to the reserved nibble leaves the offset unchanged.
    AST_RESERVED_INERT: assert property (@(posedge MCLK) disable iff (RST)
        $stable(next_sel) && $stable(trim_q[oft_pkg::SLOT_DUAL_INB][oft_pkg::FIELD_MSB:0])
        && $stable(trim_q[oft_pkg::SLOT_SINGLE_INA][oft_pkg::FIELD_MSB:0])
        && $stable(trim_q[oft_pkg::SLOT_SINGLE_INB][oft_pkg::FIELD_MSB:0])
        |=> $stable(OFFSET_A))
        else $error("Offset moved without a field or condition change.");

    // A full-word write to the dual trim is read back from the register.
    AST_WRITE_LANDS: assert property (@(posedge MCLK) disable iff (RST)
        commit_wr && trim_hit[oft_pkg::SLOT_DUAL_INB] && (&AVS_BYTEENABLE[1:0])
        |=> trim_q[oft_pkg::SLOT_DUAL_INB] == $past(AVS_WRITEDATA[oft_pkg::TRIM_W-1:0]))
        else $error("Software write did not override trim.");

    // A read of an unmapped word answers zero.
    AST_UNMAPPED_ZERO: assert property (@(posedge MCLK) disable iff (RST)
        capture_rd && !any_hit |=> AVS_READDATA == oft_pkg::RDATA_RESET)
        else $error("Unmapped read returned nonzero data.");

    // A write to an unmapped or read-only word leaves every trim as it was.
    AST_UNMAPPED_WRITE: assert property (@(posedge MCLK) disable iff (RST)
        commit_wr && !(|trim_hit) && !FUSE_LOAD
        |=> $stable(trim_q[oft_pkg::SLOT_DUAL_INB])
            && $stable(trim_q[oft_pkg::SLOT_SINGLE_INA])
            && $stable(trim_q[oft_pkg::SLOT_SINGLE_INB]))
        else $error("Write to an unmapped word changed a trim.");

    // The status word mirrors the selected slot and the applied flag.
    AST_STATUS_READ: assert property (@(posedge MCLK) disable iff (RST)
        !RST && capture_rd && status_hit
        |=> AVS_READDATA == {29'h0, $past(OFFSET_A_VALID), $past(sel)})
        else $error("Status read does not match the applied selection.");

    // A trim read returns all sixteen bits, reserved nibble included.
    AST_TRIM_READ: assert property (@(posedge MCLK) disable iff (RST)
        !RST && capture_rd && trim_hit[oft_pkg::SLOT_SINGLE_INA]
        |=> AVS_READDATA == {16'h0000, $past(trim_q[oft_pkg::SLOT_SINGLE_INA])})
        else $error("Trim read does not return the stored word.");

    // A low-lane write changes bits 7:0 only; the upper byte keeps its value.
    AST_LOW_LANE: assert property (@(posedge MCLK) disable iff (RST)
        commit_wr && trim_hit[oft_pkg::SLOT_SINGLE_INB] && AVS_BYTEENABLE[1:0] == 2'h1
        |=> trim_q[oft_pkg::SLOT_SINGLE_INB][7:0] == $past(AVS_WRITEDATA[7:0])
            && trim_q[oft_pkg::SLOT_SINGLE_INB][15:8]
            == $past(trim_q[oft_pkg::SLOT_SINGLE_INB][15:8]))
        else $error("Low-lane write disturbed the upper byte.");

    // A fuse load lands each fuse word in its own slot.
    AST_FUSE_SLOTS: assert property (@(posedge MCLK) disable iff (RST)
        !RST && FUSE_LOAD && !commit_wr
        |=> trim_q[oft_pkg::SLOT_DUAL_INB] == $past(FUSE_DUAL_INB)
            && trim_q[oft_pkg::SLOT_SINGLE_INA] == $past(FUSE_SINGLE_INA)
            && trim_q[oft_pkg::SLOT_SINGLE_INB] == $past(FUSE_SINGLE_INB))
        else $error("Fuse word landed in the wrong trim slot.");

    // Calibration on with a mode, input and phase of no trim applies nothing.
    AST_NO_MATCH: assert property (@(posedge MCLK) disable iff (RST)
        FG_CAL_EN && ((CORE_DUAL_MODE && !CORE_SAMPLE_INB)
            || (!CORE_DUAL_MODE && CORE_SAMPLE_INB && !CORE_PHASE_90))
        |=> !OFFSET_A_VALID && OFFSET_A == oft_pkg::OFFSET_RESET)
        else $error("Offset applied for an unmatched condition.");

    // A committed write ends the answer, so a held write cannot land twice.
    sequence s_write_answered;
        AVS_WRITE && answering;
    endsequence

    AST_SINGLE_COMMIT: assert property (@(posedge MCLK) disable iff (RST)
        s_write_answered |=> !answering)
        else $error("Answer state lasted more than one cycle.");

    // The upper half of the read data is always zero.
    AST_READ_HIGH_ZERO: assert property (@(posedge MCLK) disable iff (RST)
        AVS_READDATA[oft_pkg::DATA_W-1:oft_pkg::TRIM_W] == 16'h0000)
        else $error("Upper half of read data is not zero.");

endmodule

// *** dv/oft_bank_tb_top.sv ***
// Self-checking testbench for the core A offset trim register bank.
`timescale 1ns/10ps
module oft_bank_tb_top;
    // ------------------------------------------------------------------
    // Stimulus, responses and reference model
    // ------------------------------------------------------------------
    logic mclk, rst, rd, wr, fuse_load, dual, inb, ph90, cal;
    logic [oft_pkg::ADDR_W-1:0] addr;
    logic [oft_pkg::DATA_W-1:0] wdata, rdata_o, q;
    logic [oft_pkg::BEN_W-1:0] ben;
    logic waitreq, valid_o;
    logic [oft_pkg::TRIM_W-1:0] fuse [3];
    logic [oft_pkg::FIELD_W-1:0] offset_o;
    logic [31:0] seed, r;
    logic [15:0] model [3];
    int errors, checks, cycles;

    // The design under test with every input driven by the bench.
    oft_bank u_oft_bank (.MCLK(mclk), .RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(ben),
        .AVS_READDATA(rdata_o), .AVS_WAITREQUEST(waitreq), .FUSE_LOAD(fuse_load),
        .FUSE_DUAL_INB(fuse[0]), .FUSE_SINGLE_INA(fuse[1]), .FUSE_SINGLE_INB(fuse[2]),
        .CORE_DUAL_MODE(dual), .CORE_SAMPLE_INB(inb), .CORE_PHASE_90(ph90),
        .FG_CAL_EN(cal), .OFFSET_A(offset_o), .OFFSET_A_VALID(valid_o));

    // A 50 MHz clock.
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // A hung handshake is cut short after a generous cycle budget.
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            stop_test();
        end
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Xorshift generator with a fixed start value.
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("Counts: %0d checks, %0d errors", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One Avalon-MM transfer; the request holds until an edge sees waitrequest low.
    task automatic bus(input logic is_wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] b);
        @(posedge mclk);
        rd <= ~is_wr;
        wr <= is_wr;
        addr <= a;
        wdata <= d;
        ben <= b;
        @(posedge mclk);
        while (waitreq !== 1'b0) begin
            @(posedge mclk);
        end
        q = rdata_o;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    // Writes a trim slot and updates the model lane by lane.
    task automatic wr_slot(input int s, input logic [31:0] d, input logic [3:0] b);
        bus(1'b1, {oft_pkg::TRIM_IDX[s], 2'b00}, d, b);
        if (b[0]) model[s][7:0] = d[7:0];
        if (b[1]) model[s][15:8] = d[15:8];
    endtask

    // Reads back every trim slot against the model.
    task automatic rd_all();
        for (int s = 0; s < 3; s++) begin
            bus(1'b0, {oft_pkg::TRIM_IDX[s], 2'b00}, 32'h0, 4'hf);
            chk(q, {16'h0, model[s]}, "trim readback");
        end
    endtask

    // Checks the applied offset for the present core condition.
    task automatic cond_chk();
        int s;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        s = -1;
        if (cal && dual && inb) s = 0;
        else if (cal && !dual && !inb) s = 1;
        else if (cal && !dual && inb && ph90) s = 2;
        chk({31'h0, valid_o}, {31'h0, s >= 0}, "applied flag");
        chk({20'h0, offset_o}, s >= 0 ? {20'h0, model[s][11:0]} : 32'h0, "offset");
        bus(1'b0, {oft_pkg::IDX_STATUS, 2'b00}, 32'h0, 4'hf);
        chk(q, s >= 0 ? 32'h5 + s : 32'h0, "status word");
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {rst, rd, wr, fuse_load, dual, inb, ph90, cal} = 8'h80;
        {addr, wdata, ben, errors, checks} = '0;
        fuse = '{16'h0, 16'h0, 16'h0};
        model = '{16'h0, 16'h0, 16'h0};
        seed = 32'hca26;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        // Every trim and the applied offset start at zero.
        rd_all();
        cond_chk();
        $display("Test reset values done");
        // A fuse load sets each trim to its fuse word, then writes override slots 1 and 2.
        @(posedge mclk);
        for (int s = 0; s < 3; s++) begin
            r = rnd();
            model[s] = r[15:0];
            fuse[s] <= r[15:0];
        end
        fuse_load <= 1'b1;
        @(posedge mclk);
        fuse_load <= 1'b0;
        rd_all();
        wr_slot(1, rnd(), 4'h3);
        wr_slot(2, rnd(), 4'h1);
        rd_all();
        $display("Test fuse preload done");
        // Random lane writes, reserved bits included, then an unmapped place.
        for (int i = 0; i < 12; i++) begin
            r = rnd();
            wr_slot(i % 3, rnd(), r[3:0]);
            rd_all();
        end
        bus(1'b1, 12'hd2c, rnd(), 4'hf);
        bus(1'b0, 12'hd2c, 32'h0, 4'hf);
        chk(q, 32'h0, "unmapped read");
        rd_all();
        $display("Test register access done");
        // Every core condition, over two different sets of trims.
        for (int p = 0; p < 2; p++) begin
            for (int s = 0; s < 3; s++) wr_slot(s, rnd(), 4'h3);
            for (int k = 0; k < 16; k++) begin
                @(posedge mclk);
                {cal, dual, inb, ph90} <= k[3:0];
                cond_chk();
            end
        end
        $display("Test offset selection done");
        // A second reset in mid-run clears every trim and the applied offset.
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        model = '{16'h0, 16'h0, 16'h0};
        rd_all();
        cond_chk();
        $display("Test second reset done");
        stop_test();
    end
endmodule
